// [rtl/cable_diag_consts.svh]
// offsets, field positions, reset values of the cable diagnostics bank
`ifndef CABLE_DIAG_CONSTS_SVH
`define CABLE_DIAG_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_PRETEST_EN 16'h0107
`define IDX_PRETEST_ST 16'h010f
`define IDX_TDR_UPPER 16'h0c0a
`define IDX_TDR_SHADOW 16'h0c0b
`define IDX_TDR_GEAR 16'h0c0c
`define IDX_SPEC_FILT 16'h0c26
`define IDX_SPEC_TAPS 16'h0c27
`define IDX_SPEC_START 16'h0c28
`define IDX_SPEC_STEP 16'h0c29
`define IDX_SPEC_OSEL 16'h0c2a
`define IDX_RAM_ACCESS 16'h0d00
`define IDX_RAM_CTRL 16'h0d01
`define IDX_RAM_DATA 16'h0d04
// reset values
`define RST_LIMIT_6 7'h26
`define RST_LIMIT_7 7'h1f
`define RST_GROWTH 3'h1
`define RST_SHADOW_INIT 4'h6
`define RST_SKIP 5'h10
`define RST_GEAR 5'h14
`define RST_BYPASS 1'h1
`define RST_LAST_TAP 8'h1e
`define RST_FIRST_TAP 8'h00
`define RST_START_FREQ 16'h0000
`define RST_STEP 11'h400
`define RST_AVERAGE 4'ha
`define RST_MSB_SEL 4'h0
// reserved read-back patterns
`define RSV_SHADOW 16'h0000
`define RSV_GEAR 16'h0008
`define RSV_FILT 16'hc004
`define RSV_OSEL 16'h0003
`define RSV_PRETEST_ST 16'h0340
// field positions
`define BIT_RAM_EN 15
`define BIT_RESTART 15
`define BIT_SOFT_RESET 14
`define BIT_ADDR_RESET 13
`define BIT_PRETEST_EN 8
`define BIT_PRETEST_HELD 3
`define BIT_BYPASS 6
`endif

// [rtl/cable_diag_pkg.sv]
// types of the cable diagnostics bank
package cable_diag_pkg;
  typedef struct packed {
    logic [6:0] tdr_upper_peak_limit_7;
    logic [6:0] tdr_upper_peak_limit_6;
    logic [2:0] shadow_growth_factor;
    logic [3:0] shadow_initial_samples;
    logic [4:0] init_skip_samples;
    logic [4:0] gear_shift_distance;
    logic smooth_bypass;
    logic [7:0] last_tap;
    logic [7:0] first_tap;
    logic [15:0] start_freq;
    logic [3:0] average_exp;
    logic [10:0] freq_step;
    logic [3:0] output_msb_sel;
  } diag_cfg_type;
  typedef enum logic [1:0] {
    apb_idle,
    apb_access
  } apb_state_type;
endpackage

// [rtl/cable_diag_tdr_dsa_config.sv]
// register bank of the cable diagnostics engine, APB slave
//
// Contract
// - two 7-bit TDR upper peak limits 6 and 7, reset 0x26 and 0x1F.
// - 3-bit shadow growth factor in 1/128 units, reset 1.
// - 4-bit initial shadow sample count after a peak, reset 6.
// - 5-bit count of samples skipped after TDR start, reset 16.
// - 5-bit gear shift distance in samples, reset 0x14.
// - bypass bit 1 skips smoothing filter, 0 applies it; reset 1.
// - 8-bit first and last tap numbers, reset 0 and 0x1E.
// - 16-bit start frequency, 1.9 kHz per count, reset 0.
// - 11-bit frequency step, 119.2 Hz per count, reset 0x400.
// - averaging over two to the X cycles, 4-bit X, reset 0xA.
// - 4-bit MSB select picks output slice stored per memory word.
// - host memory access only while enable bit 15 is 1; reset 0.
// - writing 1 to bit 15 restarts diagnostics; 0 does nothing.
// - bit 14 at 1 holds diagnostics in soft reset.
// - bit 13 at 1 returns the memory address index to start.
// - results read as 16-bit words through data-out, reset zero.
// - bit 8 enables the pre-test configuration.
// - bit 3 of status reads 1 once pre-test setup is latched.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "cable_diag_consts.svh"
module cable_diag_tdr_dsa_config
  import cable_diag_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DEPTH = 256
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W+1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // engine side
  output diag_cfg_type diag_cfg,
  output logic diag_restart,
  output logic diag_soft_reset,
  output logic pretest_setup_enable,
  input wire logic pretest_setup_held,
  input wire logic result_wr,
  input wire logic [15:0] result_word
);

  // every flop leaves reset on the same edge, two edges after release
  logic rst_meta_reg;
  logic rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  localparam int AW = $clog2(DEPTH);

  diag_cfg_type cfg_reg;
  logic ram_en_reg;
  logic addr_reset_reg;
  logic pretest_en_reg;
  logic held_reg;
  logic restart_reg;
  logic soft_reset_reg;
  logic [15:0] data_out_reg;
  logic [AW-1:0] rd_idx_reg;
  logic [AW-1:0] wr_idx_reg;
  logic [15:0] mem [DEPTH];
  apb_state_type state_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // decode
  wire logic [15:0] idx = 16'(paddr[ADDR_W+1:2]);
  wire logic setup = psel && !penable && state_reg == apb_idle;
  // upper byte lanes carry nothing: every register sits in the low half
  wire logic wr_lo = pstrb[0];
  wire logic wr_hi = pstrb[1];
  wire logic hit_upper = idx == `IDX_TDR_UPPER;
  wire logic hit_shadow = idx == `IDX_TDR_SHADOW;
  wire logic hit_gear = idx == `IDX_TDR_GEAR;
  wire logic hit_filt = idx == `IDX_SPEC_FILT;
  wire logic hit_taps = idx == `IDX_SPEC_TAPS;
  wire logic hit_start = idx == `IDX_SPEC_START;
  wire logic hit_step = idx == `IDX_SPEC_STEP;
  wire logic hit_osel = idx == `IDX_SPEC_OSEL;
  wire logic hit_ramen = idx == `IDX_RAM_ACCESS;
  wire logic hit_ramctl = idx == `IDX_RAM_CTRL;
  wire logic hit_data = idx == `IDX_RAM_DATA;
  wire logic hit_pten = idx == `IDX_PRETEST_EN;
  wire logic hit_ptst = idx == `IDX_PRETEST_ST;
  wire logic mapped = hit_upper || hit_shadow || hit_gear || hit_filt ||
    hit_taps || hit_start || hit_step || hit_osel || hit_ramen ||
    hit_ramctl || hit_data || hit_pten || hit_ptst;
  // writes and pops commit at the edge that completes the transfer, so a
  // register never changes before the master has seen ready
  wire logic access = psel && penable && state_reg == apb_access;
  wire logic do_wr = access && pwrite && mapped;
  wire logic do_rd = access && !pwrite && mapped;
  // data-out reads pop only when host access is open
  wire logic pop = do_rd && hit_data && ram_en_reg;
  // write enables of the control registers
  wire logic wr_ramen = do_wr && hit_ramen;
  wire logic wr_ramctl = do_wr && hit_ramctl;
  wire logic wr_pten = do_wr && hit_pten;
  wire logic wr_ptst = do_wr && hit_ptst;
  wire logic wr_data = do_wr && hit_data;
  // only words that are really stored advance the write index
  wire logic engine_wr = result_wr && !ram_en_reg && !soft_reset_reg &&
    !addr_reset_reg;

  // 16-bit merge honouring byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic lo,
                                          input logic hi);
    merge16 = {hi ? wd[15:8] : old_v[15:8], lo ? wd[7:0] : old_v[7:0]};
  endfunction

  // memory address step; the index wraps at DEPTH, so results beyond the
  // depth overwrite the oldest words
  function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] cur);
    next_idx = cur + AW'(1);
  endfunction

  wire logic [15:0] upper_view = {1'b0, cfg_reg.tdr_upper_peak_limit_7,
    1'b0, cfg_reg.tdr_upper_peak_limit_6};
  wire logic [15:0] shadow_view = `RSV_SHADOW |
    {4'h0, cfg_reg.shadow_growth_factor, cfg_reg.shadow_initial_samples,
     cfg_reg.init_skip_samples};
  wire logic [15:0] gear_view = `RSV_GEAR |
    {7'h00, cfg_reg.gear_shift_distance, 4'h0};
  wire logic [15:0] filt_view = `RSV_FILT |
    {9'h000, cfg_reg.smooth_bypass, 6'h00};
  wire logic [15:0] taps_view = {cfg_reg.last_tap, cfg_reg.first_tap};
  wire logic [15:0] step_view = {cfg_reg.average_exp, 1'b0,
    cfg_reg.freq_step};
  wire logic [15:0] osel_view = `RSV_OSEL |
    {cfg_reg.output_msb_sel, 12'h000};
  wire logic [15:0] ramen_view = {ram_en_reg, 15'h0000};
  wire logic [15:0] ramctl_view = {restart_reg, soft_reset_reg,
    addr_reset_reg, 13'h0000};
  wire logic [15:0] pten_view = {7'h00, pretest_en_reg, 8'h00};
  wire logic [15:0] ptst_view = `RSV_PRETEST_ST |
    {12'h000, held_reg, 3'h0};
  wire logic [15:0] mem_word = mem[rd_idx_reg];
  wire logic [15:0] rd_mux =
    hit_upper ? upper_view :
    hit_shadow ? shadow_view :
    hit_gear ? gear_view :
    hit_filt ? filt_view :
    hit_taps ? taps_view :
    hit_start ? cfg_reg.start_freq :
    hit_step ? step_view :
    hit_osel ? osel_view :
    hit_ramen ? ramen_view :
    hit_ramctl ? ramctl_view :
    hit_data ? (ram_en_reg ? mem_word : data_out_reg) :
    hit_pten ? pten_view :
    hit_ptst ? ptst_view : 16'h0000;

  wire logic [15:0] wmask_upper = merge16(upper_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_shadow = merge16(shadow_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_gear = merge16(gear_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_filt = merge16(filt_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_taps = merge16(taps_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_start = merge16(cfg_reg.start_freq, pwdata, wr_lo,
    wr_hi);
  wire logic [15:0] wm_step = merge16(step_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_osel = merge16(osel_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_ramen = merge16(ramen_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_ramctl = merge16(ramctl_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_pten = merge16(pten_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_ptst = merge16(ptst_view, pwdata, wr_lo, wr_hi);
  wire logic [15:0] wm_data = merge16(data_out_reg, pwdata, wr_lo, wr_hi);

  // apb handshake: no wait cycle, answer in the first access cycle
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= apb_idle;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        apb_idle: begin
          pready_reg <= 1'b0;
          if (setup) begin
            state_reg <= apb_access;
            pready_reg <= 1'b1;
            // an unmapped index answers with an error and changes nothing
            pslverr_reg <= !mapped;
            prdata_reg <= {16'h0000, (pwrite ? 16'h0000 : rd_mux)};
          end
        end
        apb_access: begin
          state_reg <= apb_idle;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
      endcase
    end
  end

  // configuration fields
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_reg.tdr_upper_peak_limit_6 <= `RST_LIMIT_6;
      cfg_reg.tdr_upper_peak_limit_7 <= `RST_LIMIT_7;
      cfg_reg.shadow_growth_factor <= `RST_GROWTH;
      cfg_reg.shadow_initial_samples <= `RST_SHADOW_INIT;
      cfg_reg.init_skip_samples <= `RST_SKIP;
      cfg_reg.gear_shift_distance <= `RST_GEAR;
      cfg_reg.smooth_bypass <= `RST_BYPASS;
      cfg_reg.last_tap <= `RST_LAST_TAP;
      cfg_reg.first_tap <= `RST_FIRST_TAP;
      cfg_reg.start_freq <= `RST_START_FREQ;
      cfg_reg.freq_step <= `RST_STEP;
      cfg_reg.average_exp <= `RST_AVERAGE;
      cfg_reg.output_msb_sel <= `RST_MSB_SEL;
    end else if (do_wr) begin
      // reserved bits are never stored, so they keep their pattern
      if (hit_upper) begin
        cfg_reg.tdr_upper_peak_limit_7 <= wmask_upper[14:8];
        cfg_reg.tdr_upper_peak_limit_6 <= wmask_upper[6:0];
      end
      if (hit_shadow) begin
        cfg_reg.shadow_growth_factor <= wm_shadow[11:9];
        cfg_reg.shadow_initial_samples <= wm_shadow[8:5];
        cfg_reg.init_skip_samples <= wm_shadow[4:0];
      end
      if (hit_gear) begin
        cfg_reg.gear_shift_distance <= wm_gear[8:4];
      end
      if (hit_filt) begin
        cfg_reg.smooth_bypass <= wm_filt[`BIT_BYPASS];
      end
      if (hit_taps) begin
        cfg_reg.last_tap <= wm_taps[15:8];
        cfg_reg.first_tap <= wm_taps[7:0];
      end
      if (hit_start) begin
        cfg_reg.start_freq <= wm_start;
      end
      if (hit_step) begin
        cfg_reg.average_exp <= wm_step[15:12];
        cfg_reg.freq_step <= wm_step[10:0];
      end
      if (hit_osel) begin
        cfg_reg.output_msb_sel <= wm_osel[15:12];
      end
    end
  end

  // memory control, restart pulse and pre-test bits
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ram_en_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
      addr_reset_reg <= 1'b0;
      restart_reg <= 1'b0;
      pretest_en_reg <= 1'b0;
      held_reg <= 1'b0;
    end else begin
      // restart is a one-cycle pulse; a zero write leaves the engine alone
      restart_reg <= wr_ramctl && wm_ramctl[`BIT_RESTART];
      if (wr_ramen) begin
        ram_en_reg <= wm_ramen[`BIT_RAM_EN];
      end
      if (wr_ramctl) begin
        soft_reset_reg <= wm_ramctl[`BIT_SOFT_RESET];
        addr_reset_reg <= wm_ramctl[`BIT_ADDR_RESET];
      end
      if (wr_pten) begin
        pretest_en_reg <= wm_pten[`BIT_PRETEST_EN];
      end
      // engine latch wins over a software clear in the same cycle
      if (pretest_setup_held) begin
        held_reg <= 1'b1;
      end else if (wr_ptst) begin
        held_reg <= wm_ptst[`BIT_PRETEST_HELD];
      end
    end
  end

  // result memory and address indices
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_idx_reg <= '0;
      wr_idx_reg <= '0;
      data_out_reg <= 16'h0000;
    end else begin
      if (addr_reset_reg || soft_reset_reg) begin
        rd_idx_reg <= '0;
        wr_idx_reg <= '0;
      end else begin
        if (engine_wr) begin
          wr_idx_reg <= next_idx(wr_idx_reg);
        end
        if (pop) begin
          rd_idx_reg <= next_idx(rd_idx_reg);
        end
      end
      if (pop) begin
        data_out_reg <= mem_word;
      end else if (wr_data) begin
        data_out_reg <= wm_data;
      end
    end
  end

  // engine writes results while host access is closed; the array has no
  // reset so that it maps onto a plain memory
  always_ff @(posedge clk) begin
    if (engine_wr) begin
      mem[wr_idx_reg] <= result_word;
    end
  end

  // outputs, all from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign diag_cfg = cfg_reg;
  assign diag_restart = restart_reg;
  assign diag_soft_reset = soft_reset_reg;
  assign pretest_setup_enable = pretest_en_reg;

endmodule // cable_diag_tdr_dsa_config

// [tb/cable_diag_tdr_dsa_config_asserts.sv]
// port assertions of the cable diagnostics register bank
`timescale 1ns/1ps
`include "cable_diag_consts.svh"
module cable_diag_tdr_dsa_config_asserts
  import cable_diag_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DEPTH = 256
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W+1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // engine side
  input wire diag_cfg_type diag_cfg,
  input wire logic diag_restart,
  input wire logic diag_soft_reset,
  input wire logic pretest_setup_enable,
  input wire logic pretest_setup_held,
  input wire logic result_wr,
  input wire logic [15:0] result_word
);
  wire [ADDR_W-1:0] idx = paddr[ADDR_W+1:2];
  wire wr = psel && penable && pready && pwrite;
  wire wr_ctl = wr && idx == `IDX_RAM_CTRL && pstrb[1];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_limit_write: assert property (wr && idx == `IDX_TDR_UPPER && pstrb[0]
    |=> diag_cfg.tdr_upper_peak_limit_6 == $past(pwdata[6:0]))
    else $error("limit 6 not taken");
  chk_bypass_write: assert property (wr && idx == `IDX_SPEC_FILT && pstrb[0]
    |=> diag_cfg.smooth_bypass == $past(pwdata[6]))
    else $error("bypass not taken");
  chk_pretest_write: assert property (wr && idx == `IDX_PRETEST_EN &&
    pstrb[1] |=> pretest_setup_enable == $past(pwdata[8]))
    else $error("pretest enable not taken");
  chk_soft_reset: assert property (wr_ctl
    |=> diag_soft_reset == $past(pwdata[14]))
    else $error("soft reset not taken");
  chk_restart_pulse: assert property (wr_ctl && pwdata[15]
    |-> ##[1:2] diag_restart)
    else $error("restart missing");
  chk_restart_once: assert property (diag_restart |=> !diag_restart)
    else $error("restart longer than one cycle");
  chk_cfg_holds: assert property (!wr |=> $stable(diag_cfg))
    else $error("config changed without write");
endmodule // cable_diag_tdr_dsa_config_asserts
bind cable_diag_tdr_dsa_config cable_diag_tdr_dsa_config_asserts #(
  .ADDR_W(ADDR_W), .DEPTH(DEPTH)) asserts_inst (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .diag_cfg(diag_cfg), .diag_restart(diag_restart),
  .diag_soft_reset(diag_soft_reset),
  .pretest_setup_enable(pretest_setup_enable),
  .pretest_setup_held(pretest_setup_held), .result_wr(result_wr),
  .result_word(result_word));

// [tb/tb.sv]
// self-checking bench of the cable diagnostics register bank
`timescale 1ns/1ps
`include "cable_diag_consts.svh"
module tb
  import cable_diag_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, held = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'h3;
  logic pready, pslverr, err, diag_restart, diag_soft_reset, ps_en;
  logic result_wr = 0;
  logic [15:0] result_word = '0;
  diag_cfg_type diag_cfg;
  int fails = 0, n_compared = 0, cyc = 0, restarts = 0;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
  // index, reset read-back, writable mask
  logic [15:0] ti [10] = '{`IDX_TDR_UPPER, `IDX_TDR_SHADOW, `IDX_TDR_GEAR,
    `IDX_SPEC_FILT, `IDX_SPEC_TAPS, `IDX_SPEC_START, `IDX_SPEC_STEP,
    `IDX_SPEC_OSEL, `IDX_PRETEST_EN, `IDX_PRETEST_ST};
  logic [15:0] tr [10] = '{16'h1f26,
    16'h02d0, 16'h0148, 16'hc044,
    16'h1e00, 16'h0000, 16'ha400,
    16'h0003, 16'h0000, 16'h0340};
  logic [15:0] tm [10] = '{16'h7f7f, 16'h0fff, 16'h01f0, 16'h0040,
    16'hffff, 16'hffff, 16'hf7ff, 16'hf000, 16'h0100, 16'h0008};
  cable_diag_tdr_dsa_config cable_diag_tdr_dsa_config_inst (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .diag_cfg(diag_cfg),
    .diag_restart(diag_restart), .diag_soft_reset(diag_soft_reset),
    .pretest_setup_enable(ps_en), .pretest_setup_held(held),
    .result_wr(result_wr), .result_word(result_word));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (diag_restart === 1'b1) restarts++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  // one apb transfer; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [15:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1;
    // no cap of its own: the cycle ceiling ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic eng(input logic [15:0] w);
    @(posedge clk);
    result_wr <= 1;
    result_word <= w;
    @(posedge clk);
    result_wr <= 0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    xfer(0, `IDX_RAM_DATA, 0);
    `CHK(rd[15:0], 16'h0000)
    xfer(0, `IDX_RAM_ACCESS, 0);
    `CHK(rd[15:0], 16'h0000)
    xfer(0, `IDX_RAM_CTRL, 0);
    `CHK(rd[15:0], 16'h0000)
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 10; k++) begin
        if (p == 0) begin
          xfer(0, ti[k], 0);
          `CHK(rd[15:0], tr[k])
        end
        xfer(1, ti[k], p ? 16'h0000 : 16'hffff);
        xfer(0, ti[k], 0);
        `CHK(rd[15:0], p ? tr[k] & ~tm[k] : tr[k] | tm[k])
      end
      `CHK(diag_cfg === {$bits(diag_cfg){p == 0}}, 1'b1)
      `CHK(ps_en, p == 0)
    end
    xfer(1, 16'h0c0d, 16'hffff);
    `CHK(err, 1'b1)
    xfer(0, 16'h0c0d, 0);
    `CHK(err, 1'b1)
    pstrb <= 4'h1;
    xfer(1, `IDX_TDR_UPPER, 16'hffff);
    pstrb <= 4'h3;
    xfer(0, `IDX_TDR_UPPER, 0);
    `CHK(rd[15:0], 16'h007f)
    `CHK(err, 1'b0)
    held <= 1;
    xfer(0, `IDX_PRETEST_ST, 0);
    `CHK(rd[15:0], 16'h0348)
    held <= 0;
    xfer(1, `IDX_RAM_CTRL, 16'h2000);
    xfer(1, `IDX_RAM_CTRL, 16'h0000);
    for (int k = 1; k < 4; k++) eng(16'(k * 16'h1111));
    xfer(1, `IDX_RAM_ACCESS, 16'hffff);
    xfer(0, `IDX_RAM_ACCESS, 0);
    `CHK(rd[15:0], 16'h8000)
    for (int k = 1; k < 4; k++) begin
      xfer(0, `IDX_RAM_DATA, 0);
      `CHK(rd[15:0], 16'(k * 16'h1111))
    end
    xfer(1, `IDX_RAM_CTRL, 16'h2000);
    xfer(1, `IDX_RAM_CTRL, 16'h0000);
    xfer(0, `IDX_RAM_DATA, 0);
    `CHK(rd[15:0], 16'h1111)
    xfer(1, `IDX_RAM_ACCESS, 16'h0000);
    xfer(0, `IDX_RAM_DATA, 0);
    `CHK(rd[15:0], 16'h1111)
    xfer(1, `IDX_RAM_DATA, 16'h5a5a);
    xfer(0, `IDX_RAM_DATA, 0);
    `CHK(rd[15:0], 16'h5a5a)
    xfer(1, `IDX_RAM_CTRL, 16'h8000);
    repeat (2) @(posedge clk);
    `CHK(restarts, 1)
    xfer(0, `IDX_RAM_CTRL, 0);
    `CHK(rd[15:0], 16'h0000)
    xfer(1, `IDX_RAM_CTRL, 16'h4000);
    @(negedge clk);
    `CHK(diag_soft_reset, 1'b1)
    `CHK(restarts, 1)
    xfer(1, `IDX_RAM_CTRL, 16'h0000);
    @(negedge clk);
    `CHK(diag_soft_reset, 1'b0)
    wrap_up();
  end
endmodule // tb
